// >>> verilog/dgb_pkg.sv
// shared constants for the deserializer gpio and back-channel block
// assumes the oscillator that paces the back channel is mclk at 20 MHz
package dgb_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] ADDR_GPIO9      = 8'h1a;
   localparam logic [7:0] ADDR_GPIO0      = 8'h1d;
   localparam logic [7:0] ADDR_GPIO12     = 8'h1e;
   localparam logic [7:0] ADDR_GPIO3      = 8'h1f;
   localparam logic [7:0] ADDR_REG56      = 8'h20;
   localparam logic [7:0] ADDR_REG78      = 8'h21;
   localparam logic [7:0] ADDR_BC_RATE    = 8'h23;
   localparam logic [7:0] ADDR_PORT_SEL   = 8'h34;
   localparam logic [7:0] ADDR_FAST_CTL   = 8'h43;
   localparam logic [7:0] ADDR_LEVELS_LO  = 8'h6e;
   localparam logic [7:0] ADDR_LEVELS_HI  = 8'h6f;
   // ==========================================================
   // field positions
   localparam int BC_RATE_SEL_BIT  = 6;
   localparam int BC_HIGH_RATE_BIT = 4;
   localparam int PORT_ONE_BIT     = 1;
   localparam int PORT_ZERO_BIT    = 0;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_CFG      = 8'h00;
   localparam logic [7:0] RST_PORT_SEL = 8'h01;
   localparam logic [7:0] RST_BC_RATE  = 8'h00;
   localparam logic [7:0] RST_FAST_CTL = 8'h00;
   // ==========================================================
   // pin configuration codes
   localparam logic [3:0] CODE_FWD_OUT    = 4'h5;
   localparam logic [3:0] CODE_INPUT      = 4'h3;
   localparam logic [3:0] CODE_DRIVE_LOW  = 4'h1;
   localparam logic [3:0] CODE_DRIVE_HIGH = 4'h9;
   // ==========================================================
   // fast channel sampling modes
   typedef enum logic [2:0] {
      FAST_NORMAL = 3'h0,
      FAST_PIN0   = 3'h1,
      FAST_PIN10  = 3'h2,
      FAST_FOUR   = 3'h3
   } dgb_fast_mode_t;
   localparam int SAMPLES_NORMAL = 1;
   localparam int SAMPLES_FOUR   = 6;
   localparam int SAMPLES_PIN10  = 10;
   localparam int SAMPLES_PIN0   = 15;
   // ==========================================================
   // back-channel timing
   localparam int OSC_MHZ         = 20;
   localparam int BC_SLOW_MBPS    = 5;
   localparam int BC_MID_MBPS     = 10;
   localparam int BC_FAST_MBPS    = 20;
   localparam logic [2:0] DIV_SLOW = 3'(OSC_MHZ / BC_SLOW_MBPS);
   localparam logic [2:0] DIV_MID  = 3'(OSC_MHZ / BC_MID_MBPS);
   localparam logic [2:0] DIV_FAST = 3'(OSC_MHZ / BC_FAST_MBPS);
   localparam int BC_FRAME_BITS   = 30;
   localparam logic [4:0] FRAME_LAST = 5'(BC_FRAME_BITS - 1);
   localparam logic [4:0] GAP_NORMAL = 5'(BC_FRAME_BITS / SAMPLES_NORMAL);
   localparam logic [4:0] GAP_FOUR   = 5'(BC_FRAME_BITS / SAMPLES_FOUR);
   localparam logic [4:0] GAP_PIN10  = 5'(BC_FRAME_BITS / SAMPLES_PIN10);
   localparam logic [4:0] GAP_PIN0   = 5'(BC_FRAME_BITS / SAMPLES_PIN0);
   localparam logic [1:0] STRAP_WAIT = 2'h2;
endpackage : dgb_pkg

// >>> verilog/dgb_sync.sv
// two-flop synchroniser for a bundle of unrelated levels
// assumes each bit is a slow level; bits are not kept coherent
`timescale 1ns/1ps
module dgb_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : dgb_sync

// >>> verilog/dgb_pad.sv
// one gpio pin: decodes its 4-bit code into drive and sample
// assumes fwd_level is already synchronised to clk
`timescale 1ns/1ps
module dgb_pad #(
   parameter bit LINKED = 1'b1
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // control
   input  wire logic       enable,
   input  wire logic [3:0] cfg,
   input  wire logic       fwd_level,
   // pin
   output logic            pin_out,
   output logic            pin_oe,
   // status
   output logic            is_input,
   output logic            is_local
);
   logic next_out;
   logic next_oe;

   always_comb begin
      next_out = 1'b0;
      next_oe  = 1'b0;
      is_input = 1'b0;
      is_local = 1'b1;
      if (cfg == dgb_pkg::CODE_DRIVE_LOW) begin
         next_oe  = enable;
      end else if (cfg == dgb_pkg::CODE_DRIVE_HIGH) begin
         next_out = enable;
         next_oe  = enable;
      end else if (cfg == dgb_pkg::CODE_INPUT) begin
         is_input = enable;
      end else if (LINKED && cfg == dgb_pkg::CODE_FWD_OUT) begin
         next_out = enable & fwd_level;
         next_oe  = enable;
      end else begin
         is_local = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pin_out <= 1'b0;
         pin_oe  <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe  <= next_oe;
      end
   end
endmodule : dgb_pad

// >>> verilog/dgb_ctrl.sv
// deserializer gpio, fast gpio and back-channel sideband control
// assumes register accesses arrive decoded on mclk; pins and link
// signals are asynchronous and are synchronised here
`timescale 1ns/1ps
module dgb_ctrl (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset_n,
   // control pins
   input  wire logic       powerdown_n_pin,
   input  wire logic       remote_interrupt_input_n,
   input  wire logic       strap_config_pin_1,
   // link state and forward channel
   input  wire logic       link_clk,
   input  wire logic [3:0] fwd_gpio,
   input  wire logic [3:0] fwd_fast_gpio,
   input  wire logic       fwd_mode_18bit,
   input  wire logic       two_lane_mode,
   input  wire logic       compat_serializer,
   input  wire logic       int_forward_enable,
   // gpio pins
   input  wire logic [3:0] gpio_in,
   output logic      [3:0] gpio_out,
   output logic      [3:0] gpio_oe,
   input  wire logic [3:0] fast_gpio_in,
   output logic      [3:0] fast_gpio_out,
   output logic      [3:0] fast_gpio_oe,
   input  wire logic [3:0] reg_gpio_in,
   output logic      [3:0] reg_gpio_out,
   output logic      [3:0] reg_gpio_oe,
   input  wire logic       gpio9_in,
   output logic            gpio9_out,
   output logic            gpio9_oe,
   output logic      [3:0] i2s_in_gated,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // back channel
   output logic            bc_bit_tick,
   output logic            bc_frame_start,
   output logic      [3:0] bc_gpio,
   output logic            bc_interrupt_n,
   output logic            fast_sample_valid,
   output logic      [3:0] fast_sample_data,
   // status
   output logic            color_mode_18bit,
   output logic            device_active
);
   // ==========================================================
   // input synchronisation
   logic       pd_n_s, intn_s, strap_s, lclk_s, m18_s;
   logic       two_lane_s, compat_s, int_fwd_s, g9_s;
   logic [3:0] gpio_s, fast_s, reg_s, fwd_s, ffwd_s;

   dgb_sync #(.W(29)) u_sync (
      .clk      (mclk),
      .reset_n  (reset_n),
      .async_in ({powerdown_n_pin, remote_interrupt_input_n,
                  strap_config_pin_1, link_clk, gpio_in, fast_gpio_in,
                  reg_gpio_in, gpio9_in, fwd_gpio, fwd_fast_gpio,
                  fwd_mode_18bit, two_lane_mode, compat_serializer,
                  int_forward_enable}),
      .sync_out ({pd_n_s, intn_s, strap_s, lclk_s, gpio_s, fast_s,
                  reg_s, g9_s, fwd_s, ffwd_s, m18_s, two_lane_s,
                  compat_s, int_fwd_s})
   );

   // ==========================================================
   // registers and link capture
   logic [7:0] cfg_bank [0:1][0:2];
   logic [7:0] next_bank [0:1][0:2];
   logic [7:0] gpio9_cfg, reg56_cfg, reg78_cfg, bc_rate, port_sel;
   logic [7:0] fast_ctl;
   logic [7:0] next_gpio9, next_reg56, next_reg78, next_bc_rate;
   logic [7:0] next_port_sel, next_fast_ctl, next_rdata;
   logic [1:0] strap_cnt, next_strap_cnt;
   logic       lclk_d;
   logic [3:0] fwd_q, ffwd_q, next_fwd_q, next_ffwd_q;
   logic       active;
   logic [1:0] dup_idx;
   logic       dup_hit;

   assign active = pd_n_s;

   always_comb begin
      dup_hit = 1'b1;
      dup_idx = 2'h0;
      if (reg_addr == dgb_pkg::ADDR_GPIO0) begin
         dup_idx = 2'h0;
      end else if (reg_addr == dgb_pkg::ADDR_GPIO12) begin
         dup_idx = 2'h1;
      end else if (reg_addr == dgb_pkg::ADDR_GPIO3) begin
         dup_idx = 2'h2;
      end else begin
         dup_hit = 1'b0;
      end
   end

   always_comb begin
      next_bank      = cfg_bank;
      next_gpio9     = gpio9_cfg;
      next_reg56     = reg56_cfg;
      next_reg78     = reg78_cfg;
      next_bc_rate   = bc_rate;
      next_port_sel  = port_sel;
      next_fast_ctl  = fast_ctl;
      next_strap_cnt = strap_cnt;
      next_fwd_q     = fwd_q;
      next_ffwd_q    = ffwd_q;
      if (lclk_s && !lclk_d) begin
         next_fwd_q  = fwd_s;
         next_ffwd_q = ffwd_s;
      end
      if (reg_write) begin
         if (dup_hit) begin
            // every selected port takes the write
            if (port_sel[dgb_pkg::PORT_ZERO_BIT]) begin
               next_bank[0][dup_idx] = reg_wdata;
            end
            if (port_sel[dgb_pkg::PORT_ONE_BIT]) begin
               next_bank[1][dup_idx] = reg_wdata;
            end
         end else if (reg_addr == dgb_pkg::ADDR_GPIO9) begin
            next_gpio9 = reg_wdata;
         end else if (reg_addr == dgb_pkg::ADDR_REG56) begin
            next_reg56 = reg_wdata;
         end else if (reg_addr == dgb_pkg::ADDR_REG78) begin
            next_reg78 = reg_wdata;
         end else if (reg_addr == dgb_pkg::ADDR_BC_RATE) begin
            next_bc_rate = reg_wdata;
         end else if (reg_addr == dgb_pkg::ADDR_PORT_SEL) begin
            next_port_sel = reg_wdata;
         end else if (reg_addr == dgb_pkg::ADDR_FAST_CTL) begin
            next_fast_ctl = reg_wdata;
         end
      end
      // strap is caught once its synchroniser has settled
      if (strap_cnt != 2'h3) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt == dgb_pkg::STRAP_WAIT && strap_s) begin
            next_bc_rate[dgb_pkg::BC_HIGH_RATE_BIT] = 1'b1;
         end
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      if (dup_hit) begin
         // port one wins when both are selected
         if (port_sel[dgb_pkg::PORT_ONE_BIT]) begin
            next_rdata = cfg_bank[1][dup_idx];
         end else begin
            next_rdata = cfg_bank[0][dup_idx];
         end
      end else if (reg_addr == dgb_pkg::ADDR_GPIO9) begin
         next_rdata = gpio9_cfg;
      end else if (reg_addr == dgb_pkg::ADDR_REG56) begin
         next_rdata = reg56_cfg;
      end else if (reg_addr == dgb_pkg::ADDR_REG78) begin
         next_rdata = reg78_cfg;
      end else if (reg_addr == dgb_pkg::ADDR_BC_RATE) begin
         next_rdata = bc_rate;
      end else if (reg_addr == dgb_pkg::ADDR_PORT_SEL) begin
         next_rdata = port_sel;
      end else if (reg_addr == dgb_pkg::ADDR_FAST_CTL) begin
         next_rdata = fast_ctl;
      end else if (reg_addr == dgb_pkg::ADDR_LEVELS_LO) begin
         next_rdata = {reg_s[2:0], 1'b0,
                       port_sel[dgb_pkg::PORT_ONE_BIT] ? fast_s
                                                       : gpio_s};
      end else if (reg_addr == dgb_pkg::ADDR_LEVELS_HI) begin
         next_rdata = {6'h00, g9_s, reg_s[3]};
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         cfg_bank   <= '{default: dgb_pkg::RST_CFG};
         gpio9_cfg  <= dgb_pkg::RST_CFG;
         reg56_cfg  <= dgb_pkg::RST_CFG;
         reg78_cfg  <= dgb_pkg::RST_CFG;
         bc_rate    <= dgb_pkg::RST_BC_RATE;
         port_sel   <= dgb_pkg::RST_PORT_SEL;
         fast_ctl   <= dgb_pkg::RST_FAST_CTL;
         strap_cnt  <= 2'h0;
         lclk_d     <= 1'b0;
         fwd_q      <= 4'h0;
         ffwd_q     <= 4'h0;
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         cfg_bank   <= next_bank;
         gpio9_cfg  <= next_gpio9;
         reg56_cfg  <= next_reg56;
         reg78_cfg  <= next_reg78;
         bc_rate    <= next_bc_rate;
         port_sel   <= next_port_sel;
         fast_ctl   <= next_fast_ctl;
         strap_cnt  <= next_strap_cnt;
         lclk_d     <= lclk_s;
         fwd_q      <= next_fwd_q;
         ffwd_q     <= next_ffwd_q;
         reg_rdata  <= reg_read ? next_rdata : 8'h00;
         reg_rvalid <= reg_read;
      end
   end

   // ==========================================================
   // pins
   logic [3:0] std_is_in, fast_is_in, reg_local;
   logic [15:0] reg_fields;
   logic       fast_en;

   assign fast_en = active & two_lane_s;
   assign reg_fields = {reg78_cfg, reg56_cfg};

   // same fields serve both pin sets through the port banks
   generate
      for (genvar i = 0; i < 4; i++) begin : g_link
         // pins 1 and 2 share the middle word
         localparam int WRD = (i == 0) ? 0 : (i == 3) ? 2 : 1;
         localparam int LSB = (i == 2) ? 4 : 0;
         logic [3:0] cfg0, cfg1;
         assign cfg0 = cfg_bank[0][WRD][LSB +: 4];
         assign cfg1 = cfg_bank[1][WRD][LSB +: 4];
         dgb_pad #(.LINKED(1'b1)) u_std (
            .clk       (mclk),
            .reset_n   (reset_n),
            .enable    (active),
            .cfg       (cfg0),
            .fwd_level (fwd_q[i]),
            .pin_out   (gpio_out[i]),
            .pin_oe    (gpio_oe[i]),
            .is_input  (std_is_in[i]),
            .is_local  ()
         );
         dgb_pad #(.LINKED(1'b1)) u_fast (
            .clk       (mclk),
            .reset_n   (reset_n),
            .enable    (fast_en),
            .cfg       (cfg1),
            .fwd_level (ffwd_q[i]),
            .pin_out   (fast_gpio_out[i]),
            .pin_oe    (fast_gpio_oe[i]),
            .is_input  (fast_is_in[i]),
            .is_local  ()
         );
         // register gpios never see forward data
         dgb_pad #(.LINKED(1'b0)) u_reg (
            .clk       (mclk),
            .reset_n   (reset_n),
            .enable    (active),
            .cfg       (reg_fields[4*i +: 4]),
            .fwd_level (1'b0),
            .pin_out   (reg_gpio_out[i]),
            .pin_oe    (reg_gpio_oe[i]),
            .is_input  (),
            .is_local  (reg_local[i])
         );
      end
   endgenerate

   dgb_pad #(.LINKED(1'b0)) u_g9 (
      .clk       (mclk),
      .reset_n   (reset_n),
      .enable    (active),
      .cfg       (gpio9_cfg[3:0]),
      .fwd_level (1'b0),
      .pin_out   (gpio9_out),
      .pin_oe    (gpio9_oe),
      .is_input  (),
      .is_local  ()
   );

   // ==========================================================
   // back channel pacing and sampling
   logic [2:0] div_sel;
   logic [1:0] div_cnt, next_div_cnt;
   logic [4:0] bit_cnt, next_bit_cnt, gap_cnt, next_gap_cnt, gap;
   logic [3:0] mask;
   logic       tick, mode_ok;

   always_comb begin
      if (compat_s) begin
         div_sel = dgb_pkg::DIV_SLOW;
      end else if (bc_rate[dgb_pkg::BC_HIGH_RATE_BIT]) begin
         div_sel = dgb_pkg::DIV_FAST;
      end else if (bc_rate[dgb_pkg::BC_RATE_SEL_BIT]) begin
         div_sel = dgb_pkg::DIV_MID;
      end else begin
         div_sel = dgb_pkg::DIV_SLOW;
      end
      mode_ok = 1'b1;
      case (dgb_pkg::dgb_fast_mode_t'(fast_ctl[2:0]))
         dgb_pkg::FAST_NORMAL: begin
            gap  = dgb_pkg::GAP_NORMAL;
            mask = 4'hf;
         end
         dgb_pkg::FAST_FOUR: begin
            gap  = dgb_pkg::GAP_FOUR;
            mask = 4'hf;
         end
         dgb_pkg::FAST_PIN10: begin
            gap  = dgb_pkg::GAP_PIN10;
            mask = 4'h3;
         end
         dgb_pkg::FAST_PIN0: begin
            gap  = dgb_pkg::GAP_PIN0;
            mask = 4'h1;
         end
         default: begin
            gap     = dgb_pkg::GAP_NORMAL;
            mask    = 4'h0;
            mode_ok = 1'b0;
         end
      endcase
      tick         = ({1'b0, div_cnt} + 3'h1) >= div_sel;
      next_div_cnt = tick ? 2'h0 : div_cnt + 2'h1;
      next_bit_cnt = bit_cnt;
      next_gap_cnt = gap_cnt;
      if (tick) begin
         next_bit_cnt = (bit_cnt == dgb_pkg::FRAME_LAST) ? 5'h00
                                                         : bit_cnt + 5'h01;
         next_gap_cnt = (gap_cnt + 5'h01 >= gap) ? 5'h00 : gap_cnt + 5'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n || !active) begin
         div_cnt           <= 2'h0;
         bit_cnt           <= 5'h00;
         gap_cnt           <= 5'h00;
         bc_bit_tick       <= 1'b0;
         bc_frame_start    <= 1'b0;
         bc_gpio           <= 4'h0;
         bc_interrupt_n    <= 1'b1;
         fast_sample_valid <= 1'b0;
         fast_sample_data  <= 4'h0;
         i2s_in_gated      <= 4'h0;
         color_mode_18bit  <= 1'b0;
         device_active     <= reset_n & active;
      end else begin
         div_cnt        <= next_div_cnt;
         bit_cnt        <= next_bit_cnt;
         gap_cnt        <= next_gap_cnt;
         bc_bit_tick    <= tick;
         bc_frame_start <= tick && bit_cnt == 5'h00;
         if (tick && bit_cnt == 5'h00) begin
            // only standard pins set to input ride the frame
            bc_gpio <= gpio_s & std_is_in;
         end
         // level, not latch: far side waits for the pin to rise
         bc_interrupt_n <= !(int_fwd_s && !intn_s);
         fast_sample_valid <= tick && gap_cnt == 5'h00 && mode_ok
                              && fast_en;
         if (tick && gap_cnt == 5'h00) begin
            fast_sample_data <= fast_s & fast_is_in & mask;
         end
         i2s_in_gated     <= reg_s & ~reg_local;
         color_mode_18bit <= compat_s & m18_s;
         device_active    <= 1'b1;
      end
   end
endmodule : dgb_ctrl

// >>> sim/dgb_ctrl_props.sv
// checker on the dgb_ctrl ports, bound into every instance
// assumes one clock mclk with synchronous active-low reset_n
`timescale 1ns/1ps
module dgb_ctrl_props (
   // clock and reset
   input wire logic       mclk,
   input wire logic       reset_n,
   // pins
   input wire logic       powerdown_n_pin,
   input wire logic       remote_interrupt_input_n,
   input wire logic       two_lane_mode,
   // register port
   input wire logic       reg_read,
   input wire logic       reg_rvalid,
   input wire logic [7:0] reg_rdata,
   // outputs
   input wire logic [3:0] gpio_oe,
   input wire logic [3:0] fast_gpio_oe,
   input wire logic [3:0] reg_gpio_oe,
   input wire logic [3:0] i2s_in_gated,
   input wire logic [3:0] bc_gpio,
   input wire logic       bc_bit_tick,
   input wire logic       bc_frame_start,
   input wire logic       bc_interrupt_n,
   input wire logic       fast_sample_valid,
   input wire logic       device_active
);
   // ==========================================================
   // ticks since the last frame start
   logic [5:0] tcnt, next_tcnt;
   logic       seen, next_seen;
   always_comb begin
      next_tcnt = bc_frame_start ? 6'h00 : tcnt + 6'(bc_bit_tick);
      next_seen = device_active && (seen || bc_frame_start);
   end
   always_ff @(posedge mclk) begin
      tcnt <= reset_n ? next_tcnt : 6'h00;
      seen <= reset_n ? next_seen : 1'b0;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // properties
   property p_rd_answer; reg_read |=> reg_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no answer");
   property p_rd_idle; !reg_rvalid |-> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray data");
   property p_fr_tick; bc_frame_start |-> bc_bit_tick; endproperty
   a_fr_tick: assert property (p_fr_tick) else $error("start off tick");
   property p_fr_len; bc_frame_start && seen |-> tcnt == 6'h1d; endproperty
   a_fr_len: assert property (p_fr_len) else $error("frame length");
   property p_gp_fr;
      $changed(bc_gpio) && $past(device_active) && device_active
         |-> bc_frame_start;
   endproperty
   a_gp_fr: assert property (p_gp_fr) else $error("gpio mid frame");
   property p_int; remote_interrupt_input_n [*5] |-> bc_interrupt_n; endproperty
   a_int: assert property (p_int) else $error("false interrupt");
   property p_pd;
      !powerdown_n_pin [*5] |-> !device_active
         && (gpio_oe | fast_gpio_oe | reg_gpio_oe) == 4'h0;
   endproperty
   a_pd: assert property (p_pd) else $error("active in power down");
   property p_lane;
      !two_lane_mode [*5] |-> fast_gpio_oe == 4'h0 && !fast_sample_valid;
   endproperty
   a_lane: assert property (p_lane) else $error("fast pins one lane");
   property p_i2s; (i2s_in_gated & reg_gpio_oe) == 4'h0; endproperty
   a_i2s: assert property (p_i2s) else $error("i2s not gated");
endmodule : dgb_ctrl_props
bind dgb_ctrl dgb_ctrl_props dgb_ctrl_props_i (.*);

// >>> sim/dgb_ser_model.sv
// serializer stand-in: forward link clock and gpio data
// assumes the bench holds send high while a frame runs
`timescale 1ns/1ps
module dgb_ser_model (
   // control
   input  wire logic       send,
   input  wire logic [7:0] ser_data,
   // link
   output logic            link_clk,
   output logic      [3:0] fwd_gpio,
   output logic      [3:0] fwd_fast_gpio
);
   // mirrored codes of a linked pin on this side
   localparam logic [3:0] SER_FWD  = 4'h3;
   localparam logic [3:0] SER_BACK = 4'h5;
   initial begin
      link_clk = 1'b0;
      {fwd_fast_gpio, fwd_gpio} = 8'h00;
      forever begin
         #200;
         // clock stands still outside frames
         if (send) link_clk = ~link_clk;
         if (!link_clk) {fwd_fast_gpio, fwd_gpio} = ser_data;
      end
   end
endmodule : dgb_ser_model

// >>> sim/tb.sv
// self-checking bench for dgb_ctrl against a register model
// assumes dgb_ser_model supplies the forward link
`timescale 1ns/1ps
module tb;
   logic mclk, reset_n, powerdown_n_pin, remote_interrupt_input_n;
   logic strap_config_pin_1, link_clk, fwd_mode_18bit, two_lane_mode;
   logic compat_serializer, int_forward_enable, gpio9_in, gpio9_out;
   logic gpio9_oe, reg_write, reg_read, reg_rvalid, bc_bit_tick, send;
   logic bc_frame_start, bc_interrupt_n, fast_sample_valid;
   logic color_mode_18bit, device_active;
   logic [3:0] fwd_gpio, fwd_fast_gpio, gpio_in, gpio_out, gpio_oe;
   logic [3:0] fast_gpio_in, fast_gpio_out, fast_gpio_oe, reg_gpio_in;
   logic [3:0] reg_gpio_out, reg_gpio_oe, i2s_in_gated, bc_gpio;
   logic [3:0] fast_sample_data;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, ser_data, a;
   logic [7:0] m [logic [7:0]], b0 [logic [7:0]], b1 [logic [7:0]];
   logic [7:0] adr [10] = '{8'h1a, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21,
                            8'h23, 8'h34, 8'h43, 8'h55};
   logic [7:0] ps [5] = '{8'h03, 8'h02, 8'h00, 8'h01, 8'h03};
   logic [15:0] pc [10] = '{16'h1d05, 16'h1e33, 16'h1f07, 16'h2033,
      16'h2133, 16'h1a03, 16'h2091, 16'h2119, 16'h1a09, 16'h1f09};
   logic [11:0] rt [5] = '{12'h800, 12'h440, 12'h210, 12'h250, 12'h950};
   logic [11:0] ft [5] = '{12'h01f, 12'h36f, 12'h2a3, 12'h1f1, 12'h400};
   int n_mismatch = 0, tests_run = 0, seed = 88, g;
   dgb_ctrl dgb_ctrl_i (.*);
   dgb_ser_model dgb_ser_model_i (.*);
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // ==========================================================
   // tasks
   task automatic chk(input logic [7:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask : cyc
   function automatic logic [7:0] ex(input logic [7:0] ad);
      if (ad inside {[8'h1d:8'h1f]}) return m[8'h34][1] ? b1[ad] : b0[ad];
      return m.exists(ad) ? m[ad] : 8'h00;
   endfunction : ex
   task automatic wrr(input logic [7:0] ad, d);
      reg_addr = ad; reg_wdata = d; reg_write = 1'b1; cyc(1);
      reg_write = 1'b0; cyc(1);
      if (ad inside {[8'h1d:8'h1f]}) begin
         if (m[8'h34][0]) b0[ad] = d;
         if (m[8'h34][1]) b1[ad] = d;
      end else if (m.exists(ad)) m[ad] = d;
   endtask : wrr
   task automatic rdr(input logic [7:0] ad, e);
      reg_addr = ad; reg_read = 1'b1; cyc(1);
      reg_read = 1'b0;
      chk(8'(reg_rvalid), 8'h01);
      chk(reg_rdata, e);
      cyc(1);
   endtask : rdr
   task automatic gap(output int k);
      k = 0; cyc(20);
      while (bc_bit_tick !== 1'b1 && k < 50) begin cyc(1); k++; end
      k = 0;
      do begin cyc(1); k++; end while (bc_bit_tick !== 1'b1 && k < 50);
   endtask : gap
   task automatic frm(output int c);
      int k;
      c = 0; k = 0;
      while (bc_frame_start !== 1'b1 && k < 99) begin cyc(1); k++; end
      do begin
         cyc(1); k++;
         if (fast_sample_valid === 1'b1) c++;
      end while (bc_frame_start !== 1'b1 && k < 199);
   endtask : frm
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   initial begin
      #400000;
      n_mismatch++;
      test_done;
   end
   // ==========================================================
   // main sequence
   initial begin
      {reset_n, powerdown_n_pin, remote_interrupt_input_n} = 3'h3;
      {fwd_mode_18bit, two_lane_mode, compat_serializer, gpio9_in, send,
       int_forward_enable, reg_read, reg_write, strap_config_pin_1} = '0;
      {reg_addr, reg_wdata, ser_data, gpio_in, fast_gpio_in, reg_gpio_in} = '0;
      foreach (adr[i]) {m[adr[i]], b0[adr[i]], b1[adr[i]]} = '0;
      m.delete(8'h55);
      m[8'h34] = 8'h01;
      cyc(2); reset_n = 1'b1; cyc(3);
      foreach (adr[i]) rdr(adr[i], ex(adr[i]));
      repeat (20) begin
         a = adr[{$random(seed)} % 10];
         wrr(a, 8'($random(seed)));
         rdr(a, ex(a));
      end
      foreach (ps[i]) begin
         wrr(8'h34, ps[i]);
         wrr(8'h1d, 8'($random(seed)));
         rdr(8'h1d, ex(8'h1d));
      end
      $display("test registers done");
      wrr(8'h23, 8'h00); wrr(8'h34, 8'h01);
      for (int i = 0; i < 6; i++) wrr(pc[i][15:8], pc[i][7:0]);
      ser_data = 8'($random(seed)); gpio_in = 4'($random(seed));
      gpio_in[0] = ser_data[0];
      reg_gpio_in = 4'($random(seed)); gpio9_in = 1'($random(seed));
      send = 1'b1; cyc(260); send = 1'b0;
      chk(8'(gpio_oe), 8'h01);
      chk(8'(gpio_out[0]), 8'(ser_data[0]));
      chk(8'(bc_gpio), 8'({1'b0, gpio_in[2:1], 1'b0}));
      rdr(8'h6e, {reg_gpio_in[2:0], 1'b0, gpio_in});
      rdr(8'h6f, {6'h00, gpio9_in, reg_gpio_in[3]});
      for (int i = 6; i < 10; i++) wrr(pc[i][15:8], pc[i][7:0]);
      chk(8'({gpio_oe, gpio_out[3]}), 8'h13);
      chk({reg_gpio_oe, reg_gpio_out}, 8'hf6);
      chk({i2s_in_gated, 2'h0, gpio9_oe, gpio9_out}, 8'h03);
      wrr(8'h1a, 8'h05);
      chk(8'(gpio9_oe), 8'h00);
      $display("test pins done");
      foreach (rt[i]) begin
         compat_serializer = rt[i][8];
         wrr(8'h23, rt[i][7:0]);
         gap(g);
         chk(8'(g), 8'(rt[i][11:9]));
      end
      compat_serializer = 1'b0;
      $display("test rates done");
      two_lane_mode = 1'b1; fast_gpio_in = 4'($random(seed));
      wrr(8'h23, 8'h10); wrr(8'h34, 8'h02);
      for (int i = 8'h1d; i < 8'h20; i++) wrr(8'(i), 8'h33);
      foreach (ft[i]) begin
         wrr(8'h43, 8'(ft[i][11:8]));
         frm(g); frm(g);
         chk(8'(g), 8'(ft[i][7:4]));
         if (g > 0) chk(8'(fast_sample_data), 8'(fast_gpio_in & ft[i][3:0]));
      end
      two_lane_mode = 1'b0; wrr(8'h43, 8'h03); cyc(6); frm(g); frm(g);
      chk(8'(g), 8'h00);
      $display("test fast gpio done");
      int_forward_enable = 1'b1; remote_interrupt_input_n = 1'b0; cyc(6);
      chk(8'(bc_interrupt_n), 8'h00);
      remote_interrupt_input_n = 1'b1; cyc(6);
      chk(8'(bc_interrupt_n), 8'h01);
      int_forward_enable = 1'b0; remote_interrupt_input_n = 1'b0; cyc(6);
      chk(8'(bc_interrupt_n), 8'h01);
      compat_serializer = 1'b1; fwd_mode_18bit = 1'b1; cyc(6);
      chk(8'(color_mode_18bit), 8'h01);
      powerdown_n_pin = 1'b0; cyc(6);
      chk(8'({device_active, gpio_oe, reg_gpio_oe[2:0]}), 8'h00);
      powerdown_n_pin = 1'b1; cyc(6);
      chk(8'(device_active), 8'h01);
      $display("test sideband done");
      test_done;
   end
endmodule : tb
